// [design/arc_adc_ctrl.sv]
`timescale 1ns/1ns
// Contract
// - wide result low six bits read zero
// - conversion end loads approximation into result
// - upper result bits high byte, low two
// - wide result one access, reset zero
// - control writes may spoil results
// - narrow result holds upper eight bits
// - result reads insert one wait cycle
// - channel and pin writes insert wait
// - channel codes zero to four, others prohibited
// - code k makes k low pins digital
// - registers take single-bit and byte writes
// - output-mode pin cannot be analog input
// - direction bits, top three read one
// - converting digital or output pin prohibited
// - run bit starts repeating conversions
// - completion stores result, raises done request
// - channel rewrite restarts current conversion
module arc_adc_ctrl (
    input  wire logic        clk,         // peripheral clock
    input  wire logic        rst_b,       // async reset, active low
    input  wire logic [15:0] busAddr,     // cpu byte address
    input  wire logic        busRd,       // read request
    input  wire logic        busWr,       // write request
    input  wire logic        busWide,     // 16-bit access
    input  wire logic        busBit,      // single-bit write
    input  wire logic [2:0]  busBitIdx,   // bit number for busBit
    input  wire logic [7:0]  busWData,    // write data
    output logic      [15:0] busRData,    // read data
    output logic             busAck,      // access done pulse
    output logic             busWait,     // inserted wait cycle
    input  wire logic        compHigh,    // comparator: input >= tap
    output logic      [9:0]  tapCode,     // ladder tap code
    output logic             sampleHold,  // 1 = sampling
    output logic             compEnable,  // comparator power
    output logic      [2:0]  convChannel, // selected analog input
    output logic      [4:0]  pinAnalog,   // 1 = pin in analog use
    output logic      [4:0]  pinDrive_b,  // low = output buffer on
    output logic             selFault,    // prohibited selection
    output logic             convDoneIrq  // conversion-done pulse
);
    // ==========================================================
    // state
    logic [4:0]  dir_ff, nxt_dir;
    logic [7:0]  mode_ff, nxt_mode;
    logic [2:0]  chan_ff, nxt_chan;
    logic [2:0]  pinCfg_ff, nxt_pinCfg;
    logic [9:0]  res_ff, nxt_res;
    logic [15:0] rData_ff, nxt_rData;
    logic        ack_ff, nxt_ack;
    logic        wait_ff, nxt_wait;
    logic        pend_ff, nxt_pend;
    logic        restart_ff, nxt_restart;
    logic        irq_ff, nxt_irq;
    logic [4:0]  analog_ff, nxt_analog;
    logic        fault_ff, nxt_fault;

    logic [15:0] rdMux;
    logic [7:0]  wv;
    logic        accept;
    logic        needWait;
    logic        wrEn;
    logic [4:0]  analogMask;
    logic        chanOk;
    logic [7:0]  resUpper;

    arc_conv_if cif ();

    // single-bit write replaces one bit of the current byte
    function automatic logic [7:0] mergeWr(input logic [7:0] cur,
                                           input logic       bitOp,
                                           input logic [2:0] idx,
                                           input logic [7:0] d);
        logic [7:0] m;
        m      = cur;
        m[idx] = d[0];
        return bitOp ? m : d;
    endfunction

    // ==========================================================
    // sub-blocks
    arc_sar_seq i_arc_sar_seq (
        .clk   (clk),
        .rst_b (rst_b),
        .cif   (cif.seq)
    );

    arc_pin_map #(
        .PIN_CNT (arc_pkg::PIN_CNT)
    ) i_arc_pin_map (
        .pinCfg     (pinCfg_ff),
        .dirBits    (dir_ff),
        .chanSel    (chan_ff),
        .analogMask (analogMask),
        .chanOk     (chanOk)
    );

    assign cif.run        = mode_ff[arc_pkg::MODE_RUN_BIT];
    assign cif.restart    = restart_ff;
    assign cif.frSel      = mode_ff[arc_pkg::MODE_FR_LSB +: 3];
    assign cif.longSample = (mode_ff[arc_pkg::MODE_LV_LSB +: 2] != 2'h0);
    assign cif.compHigh   = compHigh;
    assign resUpper       = res_ff[9:2];

    // ==========================================================
    // read view; unmapped addresses read zero
    always_comb begin
        case (busAddr)
            arc_pkg::ADDR_RES_LO:
                rdMux = busWide ? {res_ff, 6'h00}
                                : {8'h00, res_ff[1:0], 6'h00};
            arc_pkg::ADDR_RES_HI: rdMux = {8'h00, resUpper};
            arc_pkg::ADDR_DIR:
                rdMux = {8'h00, arc_pkg::DIR_TOP, dir_ff};
            arc_pkg::ADDR_MODE:   rdMux = {8'h00, mode_ff};
            arc_pkg::ADDR_CHAN:   rdMux = {13'h0000, chan_ff};
            arc_pkg::ADDR_PINCFG: rdMux = {13'h0000, pinCfg_ff};
            default:              rdMux = 16'h0000;
        endcase
    end

    // ==========================================================
    // bus handshake and register writes
    always_comb begin
        accept   = (busRd | busWr) & ~pend_ff;
        needWait = busRd ? (busAddr == arc_pkg::ADDR_RES_LO ||
                            busAddr == arc_pkg::ADDR_RES_HI)
                         : (busAddr == arc_pkg::ADDR_CHAN ||
                            busAddr == arc_pkg::ADDR_PINCFG ||
                            busAddr == arc_pkg::ADDR_MODE);
        wrEn     = accept & busWr & ~busWide;
        wv       = mergeWr(rdMux[7:0], busBit, busBitIdx, busWData);

        nxt_dir     = dir_ff;
        nxt_mode    = mode_ff;
        nxt_chan    = chan_ff;
        nxt_pinCfg  = pinCfg_ff;
        nxt_restart = 1'b0;
        // results are left as they stand; a control write during a
        // conversion can spoil the next result, not the stored one
        if (wrEn) begin
            case (busAddr)
                arc_pkg::ADDR_DIR:  nxt_dir  = wv[4:0];
                arc_pkg::ADDR_MODE: nxt_mode = wv & arc_pkg::MODE_MASK;
                arc_pkg::ADDR_CHAN: begin
                    nxt_chan    = wv[2:0];
                    nxt_restart = 1'b1;
                end
                arc_pkg::ADDR_PINCFG: nxt_pinCfg = wv[2:0];
                default: ;
            endcase
        end

        nxt_ack   = 1'b0;
        nxt_wait  = 1'b0;
        nxt_pend  = 1'b0;
        nxt_rData = rData_ff;
        // requests seen during the wait cycle are dropped
        if (pend_ff) begin
            nxt_ack = 1'b1;
        end else if (accept) begin
            if (busRd) begin
                nxt_rData = rdMux;
            end
            if (needWait) begin
                nxt_wait = 1'b1;
                nxt_pend = 1'b1;
            end else begin
                nxt_ack = 1'b1;
            end
        end
    end

    // ==========================================================
    // result capture, done request and pin status
    always_comb begin
        nxt_res    = cif.done ? cif.sar : res_ff;
        nxt_irq    = cif.done;
        nxt_analog = analogMask;
        nxt_fault  = ~chanOk;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dir_ff     <= arc_pkg::RST_DIR[4:0];
            mode_ff    <= arc_pkg::RST_MODE;
            chan_ff    <= arc_pkg::RST_CHAN;
            pinCfg_ff  <= arc_pkg::RST_PINCFG;
            res_ff     <= arc_pkg::RST_RES;
            rData_ff   <= 16'h0000;
            ack_ff     <= 1'b0;
            wait_ff    <= 1'b0;
            pend_ff    <= 1'b0;
            restart_ff <= 1'b0;
            irq_ff     <= 1'b0;
            analog_ff  <= 5'h1F;
            fault_ff   <= 1'b0;
        end else begin
            dir_ff     <= nxt_dir;
            mode_ff    <= nxt_mode;
            chan_ff    <= nxt_chan;
            pinCfg_ff  <= nxt_pinCfg;
            res_ff     <= nxt_res;
            rData_ff   <= nxt_rData;
            ack_ff     <= nxt_ack;
            wait_ff    <= nxt_wait;
            pend_ff    <= nxt_pend;
            restart_ff <= nxt_restart;
            irq_ff     <= nxt_irq;
            analog_ff  <= nxt_analog;
            fault_ff   <= nxt_fault;
        end
    end

    // ==========================================================
    // outputs
    assign busRData    = rData_ff;
    assign busAck      = ack_ff;
    assign busWait     = wait_ff;
    assign tapCode     = cif.tap;
    assign sampleHold  = cif.sampling;
    assign compEnable  = mode_ff[arc_pkg::MODE_CMP_BIT];
    assign convChannel = chan_ff;
    assign pinAnalog   = analog_ff;
    assign pinDrive_b  = dir_ff;
    assign selFault    = fault_ff;
    assign convDoneIrq = irq_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_RES_LOAD: assert property (
        cif.done |=> res_ff == $past(cif.sar))
        else $error("result not loaded at conversion end");
    AST_WIDE_LOW: assert property (
        (accept && busRd && busWide && busAddr == arc_pkg::ADDR_RES_LO)
        |=> busWait ##1 (busAck && busRData[5:0] == 6'h00))
        else $error("wide result low bits not zero");
    AST_NARROW: assert property (
        (accept && busRd && busAddr == arc_pkg::ADDR_RES_HI)
        |=> busWait ##1 (busAck && busRData[7:0] == $past(resUpper, 2)))
        else $error("narrow result wrong");
    AST_CHAN_WAIT: assert property (
        (wrEn && busAddr == arc_pkg::ADDR_CHAN)
        |=> (busWait && !busAck) ##1 (busAck && !busWait))
        else $error("channel write without wait cycle");
    AST_CHAN_ZERO: assert property (
        (accept && busRd && busAddr == arc_pkg::ADDR_CHAN)
        |=> (busAck && busRData[15:3] == 13'h0000))
        else $error("channel upper bits not zero");
    AST_DIR_TOP: assert property (
        (accept && busRd && busAddr == arc_pkg::ADDR_DIR)
        |=> (busAck && busRData[7:5] == 3'h7))
        else $error("direction upper bits not one");
    AST_PIN_MAP: assert property (
        (pinCfg_ff == 3'h2) |=> pinAnalog == 5'h1C)
        else $error("pin map wrong for code two");
    AST_SEL_FAULT: assert property (
        (chan_ff == 3'h0 && !dir_ff[0]) |=> selFault)
        else $error("output-mode pin accepted as analog");
    AST_BAD_CHAN: assert property (
        (chan_ff > 3'(arc_pkg::CHAN_MAX)) |=> selFault)
        else $error("prohibited channel code not flagged");
    AST_IRQ: assert property (
        cif.done |=> (convDoneIrq ##1 !convDoneIrq))
        else $error("done request not a single pulse");
    AST_RESTART_REQ: assert property (
        (wrEn && busAddr == arc_pkg::ADDR_CHAN) |=> restart_ff)
        else $error("channel write did not restart");
    AST_RES_WAIT: assert property (
        (accept && busRd && (busAddr == arc_pkg::ADDR_RES_LO ||
                             busAddr == arc_pkg::ADDR_RES_HI))
        |=> (busWait && !busAck) ##1 (busAck && !busWait))
        else $error("result read without wait cycle");
    AST_CFG_ZERO: assert property (
        (accept && busRd && busAddr == arc_pkg::ADDR_PINCFG)
        |=> (busAck && busRData[15:3] == 13'h0000))
        else $error("pin config upper bits not zero");
    AST_SEL_LEGAL: assert property (
        (chan_ff == 3'h4 && pinCfg_ff < 3'h5 && dir_ff[4]) |=> !selFault)
        else $error("legal analog selection flagged");

    COV_WIDE_RD: cover property (
        accept && busRd && busWide && busAddr == arc_pkg::ADDR_RES_LO);
    COV_IRQ: cover property (convDoneIrq);
    COV_FAULT: cover property (selFault);
    COV_RESTART: cover property (restart_ff && cif.run);
endmodule // arc_adc_ctrl

// [design/arc_conv_if.sv]
`timescale 1ns/1ns
interface arc_conv_if;
    logic                          run;        // conversion_run level
    logic                          restart;    // abort and start over
    logic [2:0]                    frSel;      // conversion time code
    logic                          longSample; // low-reference sampling
    logic                          compHigh;   // comparator answer
    logic                          done;       // one-cycle end pulse
    logic [arc_pkg::RES_BITS-1:0]  sar;        // approximation value
    logic [arc_pkg::RES_BITS-1:0]  tap;        // ladder tap code
    logic                          sampling;   // sample phase active

    modport ctrl (output run, restart, frSel, longSample, compHigh,
                  input done, sar, tap, sampling);
    modport seq  (input run, restart, frSel, longSample, compHigh,
                  output done, sar, tap, sampling);
endinterface

// [design/arc_pin_map.sv]
`timescale 1ns/1ns
module arc_pin_map #(
    parameter int PIN_CNT = arc_pkg::PIN_CNT // shared pins
) (
    input  wire logic [2:0]         pinCfg,     // digital pin count
    input  wire logic [PIN_CNT-1:0] dirBits,    // 1 = input mode
    input  wire logic [2:0]         chanSel,    // selected channel
    output logic      [PIN_CNT-1:0] analogMask, // 1 = analog use
    output logic                    chanOk      // selection legal
);
    // ==========================================================
    // the code chooses how many low pins stay digital
    if (PIN_CNT < 1 || PIN_CNT > 8) begin : g_bad
        $error("arc_pin_map: PIN_CNT out of range");
    end
    for (genvar i = 0; i < PIN_CNT; i++) begin : g_pin
        assign analogMask[i] = (3'(i) >= pinCfg);
    end

    // only an analog pin in input mode may be converted
    always_comb begin
        chanOk = 1'b0;
        for (int k = 0; k < PIN_CNT; k++) begin
            if (chanSel == 3'(k)) begin
                chanOk = analogMask[k] & dirBits[k];
            end
        end
    end
endmodule // arc_pin_map

// [design/arc_pkg.sv]
package arc_pkg;
    // ==========================================================
    // register map
    localparam logic [15:0] ADDR_RES_LO = 16'hFF08; // wide result
    localparam logic [15:0] ADDR_RES_HI = 16'hFF09; // narrow result
    localparam logic [15:0] ADDR_DIR    = 16'hFF22; // port2_direction
    localparam logic [15:0] ADDR_MODE   = 16'hFF28; // converter_mode_reg
    localparam logic [15:0] ADDR_CHAN   = 16'hFF29; // input_channel_select
    localparam logic [15:0] ADDR_PINCFG = 16'hFF2F; // analog_pin_config

    // ==========================================================
    // reset values and fixed bits
    localparam logic [7:0]  RST_DIR     = 8'hFF;
    localparam logic [7:0]  RST_MODE    = 8'h00;
    localparam logic [2:0]  RST_CHAN    = 3'h0;
    localparam logic [2:0]  RST_PINCFG  = 3'h0;
    localparam logic [9:0]  RST_RES     = 10'h000;
    localparam logic [2:0]  DIR_TOP     = 3'h7;  // upper bits read as ones
    localparam logic [7:0]  MODE_MASK   = 8'hBF; // bit 6 not implemented

    // ==========================================================
    // field layout
    localparam int RES_BITS     = 10;
    localparam int PIN_CNT      = 5;
    localparam int PINCFG_MAX   = 5;
    localparam int CHAN_MAX     = 4;
    localparam int MODE_RUN_BIT = 7;
    localparam int MODE_FR_LSB  = 3;
    localparam int MODE_LV_LSB  = 1;
    localparam int MODE_CMP_BIT = 0;

    // ==========================================================
    // conversion phases, in conversion-clock ticks
    localparam logic [4:0] CNT_CLEAR   = 5'h02;
    localparam logic [4:0] CNT_SAMP_HI = 5'h06;
    localparam logic [4:0] CNT_SAMP_LO = 5'h18;
    localparam logic [4:0] CNT_CONV    = 5'h0C;
    localparam logic [4:0] CNT_XFER    = 5'h02;

    // conversion clock divider from the time-select code
    function automatic logic [3:0] fadDiv(input logic [2:0] fr);
        case (fr)
            3'h0:    return 4'hC;
            3'h1:    return 4'h8;
            3'h2:    return 4'h6;
            3'h3:    return 4'h4;
            3'h4:    return 4'h3;
            default: return 4'h2;
        endcase
    endfunction
endpackage

// [design/arc_sar_seq.sv]
`timescale 1ns/1ns
module arc_sar_seq (
    input wire logic clk,   // peripheral clock
    input wire logic rst_b, // async reset, active low
    arc_conv_if.seq  cif    // control side
);
    typedef enum logic [2:0] {
        SEQ_IDLE, SEQ_CLEAR, SEQ_SAMPLE, SEQ_CONV, SEQ_XFER
    } arc_seq_e;

    localparam logic [4:0] RES_N = 5'(arc_pkg::RES_BITS);
    localparam logic [9:0] MSB   = 10'h200;

    arc_seq_e   seq_ff, nxt_seq;
    logic [3:0] divCnt_ff, nxt_divCnt;
    logic [4:0] phCnt_ff, nxt_phCnt;
    logic [9:0] sar_ff, nxt_sar;
    logic [9:0] tap_ff, nxt_tap;
    logic       done_ff, nxt_done;
    logic       samp_ff, nxt_samp;
    logic       tick;
    logic [4:0] phLen;
    logic [9:0] trial;

    // ==========================================================
    // sequencer: clear, sample, ten compares, transfer, repeat
    always_comb begin
        tick = (divCnt_ff >= arc_pkg::fadDiv(cif.frSel) - 4'h1);
        case (seq_ff)
            SEQ_CLEAR:  phLen = arc_pkg::CNT_CLEAR;
            SEQ_SAMPLE: phLen = cif.longSample ? arc_pkg::CNT_SAMP_LO
                                               : arc_pkg::CNT_SAMP_HI;
            SEQ_CONV:   phLen = arc_pkg::CNT_CONV;
            SEQ_XFER:   phLen = arc_pkg::CNT_XFER;
            default:    phLen = 5'h01;
        endcase
        trial      = (phCnt_ff < RES_N) ? (MSB >> phCnt_ff) : 10'h000;
        nxt_seq    = seq_ff;
        nxt_divCnt = tick ? 4'h0 : divCnt_ff + 4'h1;
        nxt_phCnt  = phCnt_ff;
        nxt_sar    = sar_ff;
        nxt_done   = 1'b0;
        if (!cif.run) begin // stop at once, last result kept
            nxt_seq    = SEQ_IDLE;
            nxt_divCnt = 4'h0;
            nxt_phCnt  = 5'h00;
        end else if (cif.restart || seq_ff == SEQ_IDLE) begin
            nxt_seq    = SEQ_CLEAR;
            nxt_divCnt = 4'h0;
            nxt_phCnt  = 5'h00;
        end else if (tick) begin
            if (seq_ff == SEQ_CONV && cif.compHigh) begin
                nxt_sar = sar_ff | trial;
            end
            if (phCnt_ff >= phLen - 5'h01) begin
                nxt_phCnt = 5'h00;
                case (seq_ff)
                    SEQ_CLEAR: begin
                        nxt_seq = SEQ_SAMPLE;
                        nxt_sar = 10'h000;
                    end
                    SEQ_SAMPLE: nxt_seq = SEQ_CONV;
                    SEQ_CONV:   nxt_seq = SEQ_XFER;
                    default: begin // back to back repeat
                        nxt_seq  = SEQ_CLEAR;
                        nxt_done = 1'b1;
                    end
                endcase
            end else begin
                nxt_phCnt = phCnt_ff + 5'h01;
            end
        end
        // tap is registered; divider of two or more gives it a cycle
        // to settle before the comparator is sampled
        nxt_tap = 10'h000;
        if (nxt_seq == SEQ_CONV && nxt_phCnt < RES_N) begin
            nxt_tap = nxt_sar | (MSB >> nxt_phCnt);
        end
        nxt_samp = (nxt_seq == SEQ_SAMPLE);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            seq_ff    <= SEQ_IDLE;
            divCnt_ff <= 4'h0;
            phCnt_ff  <= 5'h00;
            sar_ff    <= 10'h000;
            tap_ff    <= 10'h000;
            done_ff   <= 1'b0;
            samp_ff   <= 1'b0;
        end else begin
            seq_ff    <= nxt_seq;
            divCnt_ff <= nxt_divCnt;
            phCnt_ff  <= nxt_phCnt;
            sar_ff    <= nxt_sar;
            tap_ff    <= nxt_tap;
            done_ff   <= nxt_done;
            samp_ff   <= nxt_samp;
        end
    end

    assign cif.done     = done_ff;
    assign cif.sar      = sar_ff;
    assign cif.tap      = tap_ff;
    assign cif.sampling = samp_ff;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_RUN_STARTS: assert property (
        (seq_ff == SEQ_IDLE && cif.run) |=> seq_ff == SEQ_CLEAR)
        else $error("run did not start a conversion");
    AST_RESTART: assert property (
        (cif.run && cif.restart) |=> (seq_ff == SEQ_CLEAR && !done_ff))
        else $error("restart did not reinitialise");
    AST_STOP: assert property (
        !cif.run |=> (seq_ff == SEQ_IDLE && !done_ff))
        else $error("conversion kept running after stop");
    AST_DONE_XFER: assert property (
        done_ff |-> ($past(seq_ff) == SEQ_XFER && seq_ff == SEQ_CLEAR))
        else $error("done outside transfer phase");
    COV_DONE: cover property (done_ff ##[1:1000] done_ff);
endmodule // arc_sar_seq

// [dv/tb_arc_adc_ctrl.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_arc_adc_ctrl;
    logic        clk = 1'b0, rst_b = 1'b0, busRd = 1'b0, busWr = 1'b0;
    logic        busWide = 1'b0, busBit = 1'b0, compHigh = 1'b0;
    logic [15:0] busAddr = 16'h0000;
    logic [2:0]  busBitIdx = 3'h0;
    logic [7:0]  busWData = 8'h00;
    logic [15:0] busRData, rd;
    logic        busAck, busWait, sampleHold, compEnable, selFault;
    logic        convDoneIrq, waited;
    logic [9:0]  tapCode;
    logic [2:0]  convChannel;
    logic [4:0]  pinAnalog, pinDrive_b;
    int          n_errors = 0, total_checks = 0, n;
    localparam logic [9:0] VIN = 10'h2A5; // held input level

    arc_adc_ctrl i_arc_adc_ctrl (
        .clk(clk), .rst_b(rst_b), .busAddr(busAddr), .busRd(busRd),
        .busWr(busWr), .busWide(busWide), .busBit(busBit),
        .busBitIdx(busBitIdx), .busWData(busWData), .busRData(busRData),
        .busAck(busAck), .busWait(busWait), .compHigh(compHigh),
        .tapCode(tapCode), .sampleHold(sampleHold),
        .compEnable(compEnable), .convChannel(convChannel),
        .pinAnalog(pinAnalog), .pinDrive_b(pinDrive_b),
        .selFault(selFault), .convDoneIrq(convDoneIrq));

    // ==========================================================
    // clock and an ideal comparator on a fixed input level
    always #5 clk = ~clk;
    // answer off the sampling edge so the tap compare never races
    always @(negedge clk) compHigh <= (VIN >= tapCode);

    task automatic final_report;
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // one bus access: request one cycle, then bounded wait for ack
    task automatic access(input logic wr, input logic [15:0] a,
                          input logic wide, input logic bitOp,
                          input logic [2:0] idx, input logic [7:0] d);
        int i;
        @(negedge clk);
        busAddr = a; busRd = !wr; busWr = wr; busWide = wide;
        busBit = bitOp; busBitIdx = idx; busWData = d;
        @(negedge clk);
        busRd = 1'b0; busWr = 1'b0; waited = busWait;
        for (i = 0; i < 4 && busAck !== 1'b1; i++) @(negedge clk);
        if (busAck !== 1'b1) begin n_errors++; final_report(); end
        else rd = busRData;
    endtask

    task automatic rc(input logic [15:0] a, input logic wide,
                      input logic [15:0] e, input logic ew);
        access(1'b0, a, wide, 1'b0, 3'h0, 8'h00);
        `CHK(wide ? rd : {8'h00, rd[7:0]}, e)
        `CHK(waited, ew)
    endtask

    task automatic wc(input logic [15:0] a, input logic [7:0] d,
                      input logic ew);
        access(1'b1, a, 1'b0, 1'b0, 3'h0, d);
        `CHK(waited, ew)
    endtask

    // bounded wait for the conversion-done pulse, n counts cycles
    task automatic waitDone(input int lim);
        for (n = 0; n < lim && convDoneIrq !== 1'b1; n++) @(negedge clk);
        if (convDoneIrq !== 1'b1) begin n_errors++; final_report(); end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        `CHK(pinDrive_b, 5'h1F)
        `CHK(pinAnalog, 5'h1F)
        rc(arc_pkg::ADDR_DIR, 1'b0, 16'h00FF, 1'b0);
        rc(arc_pkg::ADDR_CHAN, 1'b0, 16'h0000, 1'b0);
        rc(arc_pkg::ADDR_PINCFG, 1'b0, 16'h0000, 1'b0);
        rc(arc_pkg::ADDR_RES_LO, 1'b1, 16'h0000, 1'b1);
        rc(arc_pkg::ADDR_RES_HI, 1'b0, 16'h0000, 1'b1);
        // direction: top bits stick at one, single-bit write lands
        wc(arc_pkg::ADDR_DIR, 8'h00, 1'b0);
        `CHK(pinDrive_b, 5'h00)
        rc(arc_pkg::ADDR_DIR, 1'b0, 16'h00E0, 1'b0);
        access(1'b1, arc_pkg::ADDR_DIR, 1'b0, 1'b1, 3'h0, 8'h01);
        rc(arc_pkg::ADDR_DIR, 1'b0, 16'h00E1, 1'b0);
        wc(arc_pkg::ADDR_DIR, 8'hFF, 1'b0);
        wc(arc_pkg::ADDR_CHAN, 8'h07, 1'b1);
        rc(arc_pkg::ADDR_CHAN, 1'b0, 16'h0007, 1'b0);
        // every channel code, the prohibited ones flagged
        for (int c = 0; c < 8; c++) begin
            wc(arc_pkg::ADDR_CHAN, 8'(c), 1'b1);
            `CHK(convChannel, 3'(c))
            `CHK(selFault, 1'(c > 4))
        end
        // every pin code with channel 0, pin 0 digital from code 1
        wc(arc_pkg::ADDR_CHAN, 8'h00, 1'b1);
        for (int k = 0; k < 8; k++) begin
            wc(arc_pkg::ADDR_PINCFG, 8'(k) | 8'hF8, 1'b1);
            `CHK(pinAnalog, (k > 5) ? 5'h00 : 5'(5'h1F << k))
            `CHK(selFault, 1'(k > 0))
            rc(arc_pkg::ADDR_PINCFG, 1'b0, 16'(k), 1'b0);
        end
        wc(arc_pkg::ADDR_PINCFG, 8'h00, 1'b1);
        // run at the fastest clock code, conversions repeat; the cycle
        // counts stand in for a slower peripheral clock
        wc(arc_pkg::ADDR_MODE, 8'hA8, 1'b1);
        waitDone(100);
        @(negedge clk);
        `CHK(convDoneIrq, 1'b0)
        waitDone(60);
        repeat (10) @(negedge clk);
        // channel rewrite mid-conversion pushes the next done out
        wc(arc_pkg::ADDR_CHAN, 8'h00, 1'b1);
        waitDone(100);
        `CHK(1'(n >= 36), 1'b1)
        rc(arc_pkg::ADDR_RES_LO, 1'b1, {VIN, 6'h00}, 1'b1);
        rc(arc_pkg::ADDR_RES_LO, 1'b0, {8'h00, VIN[1:0], 6'h00}, 1'b1);
        rc(arc_pkg::ADDR_RES_HI, 1'b0, {8'h00, VIN[9:2]}, 1'b1);
        // stop first, time fields kept, results already read
        wc(arc_pkg::ADDR_MODE, 8'h28, 1'b1);
        `CHK(sampleHold, 1'b0)
        // low reference: range moved, 40 ticks of two cycles each
        wc(arc_pkg::ADDR_MODE, 8'h2B, 1'b1);
        `CHK(compEnable, 1'b1)
        rc(arc_pkg::ADDR_MODE, 1'b0, 16'h002B, 1'b0);
        wc(arc_pkg::ADDR_MODE, 8'hAB, 1'b1);
        waitDone(120);
        repeat (10) @(negedge clk);
        `CHK(sampleHold, 1'b1)
        waitDone(100);
        `CHK(n, 70)
        wc(arc_pkg::ADDR_MODE, 8'h2B, 1'b1);
        final_report();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end
endmodule // tb_arc_adc_ctrl
